// ===== nibble_exec_consts.svh
// constants for the nibble instruction executor
`ifndef NIBBLE_EXEC_CONSTS_SVH
`define NIBBLE_EXEC_CONSTS_SVH
// opcodes of the executed subset
`define OP_RR 8'h00
`define OP_RL 8'h01
`define OP_ROR_C 8'h02
`define OP_ROL_C 8'h03
`define OP_ST_LO 8'h05
`define OP_ST_HI 8'h07
`define OP_SUB_B 8'h0A
`define OP_SUB_M 8'h0B
`define OP_XOR_M 8'h1B
`define OP_OR_M 8'h1C
`define OP_XOR_TO_M 8'h1E
`define OP_OR_TO_M 8'h1F
`define OP_SET_C 8'h2B
`define OP_RET 8'h2E
`define OP_RET_INT 8'h2F
`define OP_OUT 8'h30
`define OP_TMR_ON 8'h38
`define OP_TMR_OFF 8'h39
`define OP_TMR_LO 8'h3C
`define OP_TMR_HI 8'h3D
`define OP_NOP 8'h3E
`define OP_SUB_I 8'h41
`define OP_XOR_I 8'h43
`define OP_OR_I 8'h44
`define OP_SND_N 8'h45
`define OP_TMR_LD 8'h47
`define OP_SND_ONE 8'h48
`define OP_SND_LOOP 8'h49
`define OP_SND_OFF 8'h4A
`define OP_SND_A 8'h4B
`define OP_RD_REG 8'h4C
`define OP_RDF_REG 8'h4D
`define OP_RD_MEM 8'h4E
`define OP_RDF_MEM 8'h4F
// move-to-register group: upper nibble and highest register index
`define OP_MOVR_HI 4'h2
`define REG_MAX 3'h4
// fixed table page
`define FIXED_PAGE 4'hF
// apb register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_PC 8'h08
`define ADDR_REGS 8'h0C
`define ADDR_TIMER 8'h10
// timer prescaler terminal count; one tick every 256 clock cycles
`define TIMER_DIV 8'hFF
`endif

// ===== nibble_exec_pkg.sv
// types for the nibble instruction executor
package nibble_exec_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_FETCH = 5'h02,
        S_FETCH2 = 5'h04,
        S_EXEC = 5'h08,
        S_TABLE = 5'h10
    } state_e;
endpackage

// ===== nibble_exec.sv
// decode and execute core for the second half of a 4-bit instruction set
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "nibble_exec_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module nibble_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [12:0] rom_addr,
    input wire logic [7:0] rom_data,
    input wire logic [11:0] stack_pc,
    input wire logic saved_carry,
    output logic [3:0] output_port_a,
    output logic carry_flag,
    output logic [7:0] timer_value,
    output logic timer_running,
    output logic [3:0] sound_channel,
    output logic sound_start,
    output logic sound_active,
    output logic sound_loop
);
    nibble_exec_pkg::state_e state; // sequencer state
    logic [11:0] pc; // program counter bits 11..0
    logic [7:0] opcode; // first instruction byte
    logic [7:0] imm; // second instruction byte
    logic [3:0] acc; // accumulator
    logic [3:0] wr [0:4]; // working registers zero to four
    logic [3:0] mem [0:255]; // data memory
    logic run; // software run enable
    logic [7:0] prescale; // timer tick divider
    logic rom_bank_bit; // program address bit 12 alias
    logic [7:0] pointer_pair_low; // address from registers one,zero
    logic [7:0] pointer_pair_high; // address from registers three,two
    logic [3:0] mem_lo; // memory word at the low pair
    logic exec; // executing this cycle
    logic [3:0] next_acc;
    logic next_carry;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [3:0] mem_wd;
    logic reg_we;
    logic table_rd; // opcode is one of the four table reads
    logic [12:0] table_addr;
    logic [11:0] next_pc;
    logic next_bank;
    logic apb_wr; // write completes this edge
    logic apb_setup; // setup phase sampled
    logic [31:0] rd_mux;
    logic rd_ok;

    // 4-bit add with carry in, carry out on top
    function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic ci);
        add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    // true for opcodes that carry a second byte
    function automatic logic two_byte(input logic [7:0] op);
        two_byte = (op == `OP_SUB_I) || (op == `OP_XOR_I) || (op == `OP_OR_I) ||
                   (op == `OP_SND_N) || (op == `OP_TMR_LD);
    endfunction

    assign rom_bank_bit = output_port_a[3];
    assign pointer_pair_low = {wr[1], wr[0]};
    assign pointer_pair_high = {wr[3], wr[2]};
    assign mem_lo = mem[pointer_pair_low];
    assign exec = (state == nibble_exec_pkg::S_EXEC);
    assign table_rd = (opcode[7:2] == 6'(`OP_RD_REG >> 2));
    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_setup = psel && !penable;

    // table address: page, accumulator nibble, low nibble source
    always_comb begin
        table_addr = {rom_bank_bit, pc[11:8], acc, wr[4]};
        if (opcode[0]) begin
            table_addr[11:8] = `FIXED_PAGE;
        end
        if (!opcode[1]) begin
            table_addr[3:0] = mem_lo;
        end
    end

    // next program counter and bank after execution
    always_comb begin
        next_pc = pc;
        next_bank = rom_bank_bit;
        if (opcode == `OP_RET || opcode == `OP_RET_INT) begin
            next_pc = stack_pc;
        end
        if (opcode == `OP_OUT) begin
            next_bank = acc[3];
        end
    end

    // datapath result of the current opcode
    always_comb begin
        next_acc = acc;
        next_carry = carry_flag;
        mem_we = 1'b0;
        mem_wa = pointer_pair_low;
        mem_wd = acc;
        reg_we = 1'b0;
        case (opcode)
            `OP_RR: begin
                next_acc = {acc[0], acc[3:1]};
                next_carry = acc[0];
            end
            `OP_ROR_C: begin
                next_acc = {carry_flag, acc[3:1]};
                next_carry = acc[0];
            end
            `OP_RL: begin
                next_acc = {acc[2:0], acc[3]};
                next_carry = acc[3];
            end
            `OP_ROL_C: begin
                next_acc = {acc[2:0], carry_flag};
                next_carry = acc[3];
            end
            `OP_ST_LO: mem_we = 1'b1;
            `OP_ST_HI: begin
                mem_we = 1'b1;
                mem_wa = pointer_pair_high;
            end
            `OP_SUB_B: {next_carry, next_acc} = add5(acc, ~mem_lo, carry_flag);
            `OP_SUB_M: {next_carry, next_acc} = add5(acc, ~mem_lo, 1'b1);
            `OP_SUB_I: {next_carry, next_acc} = add5(acc, ~imm[3:0], 1'b1);
            `OP_OR_I: next_acc = acc | imm[3:0];
            `OP_OR_M: next_acc = acc | mem_lo;
            `OP_OR_TO_M: begin
                mem_we = 1'b1;
                mem_wd = acc | mem_lo;
            end
            `OP_XOR_I: next_acc = acc ^ imm[3:0];
            `OP_XOR_M: next_acc = acc ^ mem_lo;
            `OP_XOR_TO_M: begin
                mem_we = 1'b1;
                mem_wd = acc ^ mem_lo;
            end
            `OP_SET_C: next_carry = 1'b1;
            `OP_RET_INT: next_carry = saved_carry;
            default: begin
                // no-operation and other opcodes leave acc, carry and memory alone; move-to-register opcodes raise reg_we
                reg_we = (opcode[7:4] == `OP_MOVR_HI) && !opcode[0] && (opcode[3:1] <= `REG_MAX);
            end
        endcase
    end

    // sequencer: fetch, second byte, execute, table read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= nibble_exec_pkg::S_IDLE;
            pc <= 12'h000;
            opcode <= `OP_NOP;
            imm <= 8'h00;
            rom_addr <= 13'h0000;
        end else begin
            case (state)
                nibble_exec_pkg::S_IDLE: begin
                    if (apb_wr && paddr == `ADDR_PC) begin
                        pc <= pwdata[11:0];
                    end
                    if (run) begin
                        rom_addr <= {rom_bank_bit, pc};
                        state <= nibble_exec_pkg::S_FETCH;
                    end
                end
                nibble_exec_pkg::S_FETCH: begin
                    opcode <= rom_data;
                    pc <= pc + 12'h001;
                    if (two_byte(rom_data)) begin
                        rom_addr <= {rom_bank_bit, pc + 12'h001};
                        state <= nibble_exec_pkg::S_FETCH2;
                    end else begin
                        state <= nibble_exec_pkg::S_EXEC;
                    end
                end
                nibble_exec_pkg::S_FETCH2: begin
                    imm <= rom_data;
                    pc <= pc + 12'h001;
                    state <= nibble_exec_pkg::S_EXEC;
                end
                nibble_exec_pkg::S_EXEC: begin
                    pc <= next_pc;
                    if (table_rd) begin
                        rom_addr <= table_addr;
                        state <= nibble_exec_pkg::S_TABLE;
                    end else if (run) begin
                        rom_addr <= {next_bank, next_pc};
                        state <= nibble_exec_pkg::S_FETCH;
                    end else begin
                        state <= nibble_exec_pkg::S_IDLE;
                    end
                end
                nibble_exec_pkg::S_TABLE: begin
                    rom_addr <= {rom_bank_bit, pc};
                    state <= run ? nibble_exec_pkg::S_FETCH : nibble_exec_pkg::S_IDLE;
                end
                default: state <= nibble_exec_pkg::S_IDLE;
            endcase
        end
    end

    // accumulator and carry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 4'h0;
            carry_flag <= 1'b0;
        end else if (exec) begin
            acc <= next_acc;
            carry_flag <= next_carry;
        end else if (state == nibble_exec_pkg::S_TABLE) begin
            acc <= rom_data[3:0];
        end
    end

    // working registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i <= 4; i++) begin
                wr[i] <= 4'h0;
            end
        end else if (exec && reg_we) begin
            wr[opcode[3:1]] <= acc;
        end else if (state == nibble_exec_pkg::S_TABLE && !opcode[1]) begin
            wr[4] <= rom_data[7:4];
        end
    end

    // data memory writes
    always_ff @(posedge pclk) begin
        if (exec && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end else if (state == nibble_exec_pkg::S_TABLE && opcode[1]) begin
            mem[pointer_pair_low] <= rom_data[7:4];
        end
    end

    // output port latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_port_a <= 4'h0;
        end else if (exec && opcode == `OP_OUT) begin
            output_port_a <= acc;
        end
    end

    // timer run control, nibble loads, preload and counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_running <= 1'b0;
            timer_value <= 8'h00;
            prescale <= 8'h00;
        end else begin
            prescale <= (prescale == `TIMER_DIV) ? 8'h00 : prescale + 8'h01;
            if (exec && opcode == `OP_TMR_ON) begin
                timer_running <= 1'b1;
            end else if (exec && opcode == `OP_TMR_OFF) begin
                timer_running <= 1'b0;
            end
            if (exec && opcode == `OP_TMR_HI) begin
                timer_value[7:4] <= acc;
            end else if (exec && opcode == `OP_TMR_LO) begin
                timer_value[3:0] <= acc;
            end else if (exec && opcode == `OP_TMR_LD) begin
                timer_value <= imm;
            end else if (timer_running && prescale == `TIMER_DIV) begin
                timer_value <= timer_value + 8'h01;
            end
        end
    end

    // sound channel commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sound_channel <= 4'h0;
            sound_start <= 1'b0;
            sound_active <= 1'b0;
            sound_loop <= 1'b0;
        end else begin
            sound_start <= 1'b0;
            if (exec && opcode == `OP_SND_N) begin
                sound_channel <= imm[3:0];
                sound_start <= 1'b1;
                sound_active <= 1'b1;
            end else if (exec && opcode == `OP_SND_A) begin
                sound_channel <= acc;
                sound_start <= 1'b1;
                sound_active <= 1'b1;
            end else if (exec && opcode == `OP_SND_OFF) begin
                sound_active <= 1'b0;
            end
            if (exec && opcode == `OP_SND_LOOP) begin
                sound_loop <= 1'b1;
            end else if (exec && opcode == `OP_SND_ONE) begin
                sound_loop <= 1'b0;
            end
        end
    end

    // apb read mux
    always_comb begin
        rd_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `ADDR_CTRL: rd_mux = {31'h0, run};
            `ADDR_STATUS: rd_mux = {24'h0, timer_running, sound_loop, sound_active, carry_flag, acc};
            `ADDR_PC: rd_mux = {19'h0, rom_bank_bit, pc};
            `ADDR_REGS: rd_mux = {12'h0, wr[4], wr[3], wr[2], wr[1], wr[0]};
            `ADDR_TIMER: rd_mux = {24'h0, timer_value};
            default: rd_ok = 1'b0;
        endcase
    end

    // apb slave: zero-wait answer, run bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            run <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !rd_ok;
            prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
            if (apb_wr && paddr == `ADDR_CTRL) begin
                run <= pwdata[0];
            end
        end
    end

    // checks
    sequence s_exec(logic [7:0] op);
        exec && opcode == op;
    endsequence
    property p_tmr_hi;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_TMR_HI) |=> timer_value == {$past(acc), $past(timer_value[3:0])};
    endproperty
    a_tmr_hi: assert property (p_tmr_hi) else $error("timer high nibble load wrong");
    // a cleared run bit sends the sequencer to idle instead of the next fetch
    property p_nop;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_NOP) |=> $stable(acc) && $stable(carry_flag) &&
            state == ($past(run) ? nibble_exec_pkg::S_FETCH : nibble_exec_pkg::S_IDLE);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_out;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_OUT) |=> output_port_a == $past(acc) &&
            (!$past(run) || rom_addr[12] == $past(acc[3]));
    endproperty
    a_out: assert property (p_out) else $error("port latch or bank wrong");
    property p_rl;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_RL) |=> acc == {$past(acc[2:0]), $past(acc[3])} && carry_flag == $past(acc[3]);
    endproperty
    a_rl: assert property (p_rl) else $error("rotate left wrong");
    property p_stc;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_SET_C) |=> carry_flag && $stable(acc);
    endproperty
    a_stc: assert property (p_stc) else $error("set carry failed");
    property p_snd_off;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_SND_OFF) |=> !sound_active && !sound_start;
    endproperty
    a_snd_off: assert property (p_snd_off) else $error("sound not stopped");
    property p_tmr_ld;
        @(posedge pclk) disable iff (!presetn)
        s_exec(`OP_TMR_LD) |=> timer_value == $past(imm);
    endproperty
    a_tmr_ld: assert property (p_tmr_ld) else $error("timer preload wrong");
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !timer_running && !exec |=> $stable(timer_value);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped timer moved");
    sequence s_two;
        state == nibble_exec_pkg::S_FETCH && two_byte(rom_data);
    endsequence
    property p_two;
        @(posedge pclk) disable iff (!presetn)
        s_two |=> state == nibble_exec_pkg::S_FETCH2 ##1 state == nibble_exec_pkg::S_EXEC &&
            pc == $past(pc, 2) + 12'h002;
    endproperty
    a_two: assert property (p_two) else $error("two-byte fetch wrong");
endmodule
`default_nettype wire

// ===== prog_rom.sv
// program rom model that feeds opcode and table bytes to the executor
`timescale 1ns/1ns
`default_nettype none
module prog_rom (
    input wire logic [12:0] rom_addr,
    output logic [7:0] rom_data
);
    // rom contents, loaded by the bench before each run
    logic [7:0] mem [0:8191];
    // combinational read: the core samples the byte one cycle after the address
    assign rom_data = mem[rom_addr];
endmodule
`default_nettype wire

// ===== tb_nibble_cpu_exec_subset.sv
// self-checking bench for the nibble instruction executor
`include "nibble_exec_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_nibble_cpu_exec_subset;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [12:0] rom_addr;
    logic [7:0] rom_data, timer_value;
    logic [11:0] stack_pc;
    logic saved_carry, carry_flag, timer_running, sound_start, sound_active, sound_loop;
    logic [3:0] output_port_a, sound_channel;
    int err_count, n_compared, cycles, starts, s0;

    // device under test
    nibble_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data), .stack_pc(stack_pc),
        .saved_carry(saved_carry), .output_port_a(output_port_a), .carry_flag(carry_flag),
        .timer_value(timer_value), .timer_running(timer_running),
        .sound_channel(sound_channel), .sound_start(sound_start),
        .sound_active(sound_active), .sound_loop(sound_loop));
    // program rom on the far side
    prog_rom rom (.rom_addr(rom_addr), .rom_data(rom_data));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // cycle ceiling and sound start pulse counter
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (sound_start === 1'b1) begin
            starts <= starts + 1;
        end
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // one comparison, counted and reported
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer: setup, then access held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    // register read and compare
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, exp, q);
        check("pslverr", 32'h0, {31'h0, e});
    endtask

    // reset held four cycles
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // fill rom with no-operation bytes, then place the program at address zero
    task automatic load(input logic [7:0] p[20]);
        for (int i = 0; i < 8192; i++) begin
            rom.mem[i] = 8'h3E;
        end
        for (int i = 0; i < 20; i++) begin
            rom.mem[i] = p[i];
        end
    endtask

    // start at pc zero, run, then stop and let the core go idle
    task automatic go();
        s0 = starts;
        wr(`ADDR_PC, 32'h0);
        wr(`ADDR_CTRL, 32'h1);
        repeat (90) @(posedge pclk);
        wr(`ADDR_CTRL, 32'h0);
        repeat (10) @(posedge pclk);
    endtask

    // reset state and an unmapped access
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        do_reset();
        rd("status", `ADDR_STATUS, 32'h0);
        rd("timer", `ADDR_TIMER, 32'h0);
        check("outputs", 32'h0, {carry_flag, sound_loop, sound_active, output_port_a});
        apb(1'b0, 8'h40, 32'h0, q, e);
        check("unmapped err", 32'h1, {31'h0, e});
    endtask

    // register moves, immediate logic, subtract, rotates, set carry, no-op
    task automatic t_alu();
        do_reset();
        load('{8'h44, 8'h05, 8'h28, 8'h20, 8'h43, 8'h0F, 8'h41, 8'h03, 8'h03, 8'h02,
               8'h01, 8'h00, 8'h2B, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E});
        go();
        rd("regs", `ADDR_REGS, 32'h0005_0005);
        rd("status alu", `ADDR_STATUS, 32'h17);
    endtask

    // memory store, memory logic, subtract with borrow and plain subtract
    task automatic t_mem();
        do_reset();
        // tail stores through the high pair (r3,r2 = 06) and reads back through r1,r0
        load('{8'h44, 8'h06, 8'h05, 8'h43, 8'h0F, 8'h1B, 8'h0A, 8'h1F, 8'h1E, 8'h0B,
               8'h1C, 8'h24, 8'h43, 8'h0F, 8'h07, 8'h43, 8'h0F, 8'h20, 8'h1B, 8'h3E});
        go();
        rd("status mem", `ADDR_STATUS, 32'h1F);
        rd("regs mem", `ADDR_REGS, 32'h0000_0606);
    endtask

    // current and fixed page table reads, then a bank switch through the port
    task automatic t_table();
        do_reset();
        load('{8'h44, 8'h03, 8'h28, 8'h4E, 8'h4C, 8'h4D, 8'h44, 8'h08, 8'h30, 8'h3E,
               8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E});
        // table bytes at the addresses built from page, accumulator and low source
        rom.mem[13'h0033] = 8'hB6;
        rom.mem[13'h006B] = 8'h2D;
        rom.mem[13'h0FDB] = 8'h71;
        rom.mem[13'h1F97] = 8'hE4;
        // code after the port write runs from the upper bank
        rom.mem[13'h1009] = 8'h4F;
        rom.mem[13'h100A] = 8'h1B;
        go();
        rd("status table", `ADDR_STATUS, 32'h0A);
        rd("regs table", `ADDR_REGS, 32'h0007_0000);
        check("port bank", 32'h9, {28'h0, output_port_a});
    endtask

    // fixed-page table read, port, timer loads and control, sound commands
    task automatic t_io();
        do_reset();
        load('{8'h44, 8'h01, 8'h4F, 8'h1B, 8'h30, 8'h47, 8'hA5, 8'h3D, 8'h43, 8'h0F,
               8'h3C, 8'h38, 8'h39, 8'h4B, 8'h45, 8'h07, 8'h49, 8'h4A, 8'h3E, 8'h3E});
        rom.mem[13'h0F10] = 8'h9C;
        go();
        rd("status io", `ADDR_STATUS, 32'h4A);
        check("port", 32'h5, {28'h0, output_port_a});
        rd("timer io", `ADDR_TIMER, 32'h5A);
        check("timer run", 32'h0, {31'h0, timer_running});
        check("sound ch", 32'h7, {28'h0, sound_channel});
        check("sound act", 32'h0, {31'h0, sound_active});
        check("sound starts", 32'h2, starts - s0);
    endtask

    // return from interrupt restores pc and carry; plain return reloads pc
    task automatic t_ret();
        do_reset();
        stack_pc <= 12'h200;
        saved_carry <= 1'b1;
        load('{8'h2F, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E,
               8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3E});
        rom.mem[13'h0200] = 8'h44;
        rom.mem[13'h0201] = 8'h03;
        rom.mem[13'h0202] = 8'h2E;
        // falling through the plain return would set the top accumulator bits
        rom.mem[13'h0203] = 8'h44;
        rom.mem[13'h0204] = 8'h0C;
        go();
        rd("status ret", `ADDR_STATUS, 32'h13);
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stack_pc = 12'h000;
        saved_carry = 1'b0;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        starts = 0;
        @(posedge pclk);
        t_reset();
        t_alu();
        t_mem();
        t_io();
        t_table();
        t_ret();
        end_of_test();
    end
endmodule
`default_nettype wire
